//--- shared/mic_defs.vh
// Offsets, field positions, reset values and timing counts of the interrupt block
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// ****************************************************
// Register offsets
// ****************************************************
`define MIC_ADDR_W          4
`define MIC_OFF_CONTROL     4'h0
`define MIC_OFF_PFLAG_A     4'h1
`define MIC_OFF_PFLAG_B     4'h2
`define MIC_OFF_PMASK_A     4'h3
`define MIC_OFF_PMASK_B     4'h4
`define MIC_OFF_EVT_STATUS  4'h5
`define MIC_OFF_EVT_MASK    4'h6
`define MIC_OFF_CORE_STATE  4'h7

// ****************************************************
// Control register fields
// ****************************************************
`define MIC_CTL_GLB_EN      7
`define MIC_CTL_PER_EN      6
`define MIC_CTL_T0_MASK     5
`define MIC_CTL_EXT_MASK    4
`define MIC_CTL_PCH_MASK    3
`define MIC_CTL_T0_FLAG     2
`define MIC_CTL_EXT_FLAG    1
`define MIC_CTL_PCH_FLAG    0

// ****************************************************
// Reset values and constants
// ****************************************************
`define MIC_CONTROL_RST     8'h00
`define MIC_PFLAG_RST       8'h00
`define MIC_PMASK_RST       8'h00
`define MIC_PFLAG_B_USED    8'h3f
`define MIC_VECTOR          13'h0004
`define MIC_PC_W            13
`define MIC_NUM_PERIPH      11
`define MIC_NUM_SOURCES     14

// ****************************************************
// Timing: clocks per instruction cycle and latency
// ****************************************************
`define MIC_CLK_PER_ICYC    4
`define MIC_LAT_MIN_ICYC    3'h3
`define MIC_LAT_MAX_ICYC    3'h4

`endif

//--- src/mic_edge.v
// Rising-edge detectors, one per source line
`timescale 1ns/1ps
`default_nettype none

module mic_edge #(
  parameter W = 3
) (
  input  wire         i_clock,
  input  wire         i_rstn,
  input  wire [W-1:0] i_level,
  output wire [W-1:0] o_rise
);

  reg [W-1:0] prev_reg;
  genvar      g;

  // Previous sample of each line
  always @(posedge i_clock)
  begin
    if (!i_rstn)
      prev_reg <= {W{1'b0}};
    else
      prev_reg <= i_level;
  end

  // ****************************************************
  // One pulse per rising edge
  // ****************************************************
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_rise
      assign o_rise[g] = i_level[g] & ~prev_reg[g];
    end
  endgenerate

endmodule
`default_nettype wire

//--- src/mic_irq_ctrl.v
// Interrupt controller of the microcontroller core
// What this block does
// - Up to fourteen interrupt sources, each with its own request flag bit.
// - Flags set on their event regardless of mask, peripheral or global enable.
// - Global enable is control bit 7; set permits unmasked, clear blocks all.
// - Take interrupt after the latency below when global enabled, no routine in service and a flag with mask set.
// - Every reset clears the global enable.
// - Return-from-interrupt leaves the routine and sets global enable again.
// - Pin, port change and timer zero flags live in the control register.
// - Peripheral flags and masks in two register pairs, gated by peripheral enable.
// - On acceptance clear global enable, push return address, jump to 0004h.
// - External events serviced three or four instruction cycles later.
`timescale 1ns/1ps
`default_nettype none
`include "mic_defs.vh"

module mic_irq_ctrl (
  input  wire                   i_clock,
  input  wire                   i_rstn,
  input  wire [`MIC_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata,
  input  wire                   i_external_irq_pin,
  input  wire                   i_port_change,
  input  wire                   i_timer_zero_ovf,
  input  wire [10:0]            i_periph_event,
  input  wire                   i_icyc_end,
  input  wire                   i_return_from_irq,
  input  wire [`MIC_PC_W-1:0]   i_return_pc,
  output reg                    o_vector_take,
  output reg  [`MIC_PC_W-1:0]   o_vector_pc,
  output reg                    o_stack_push,
  output reg  [`MIC_PC_W-1:0]   o_stack_data,
  output reg                    o_irq
);

  // ****************************************************
  // Declarations
  // ****************************************************
  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_WAIT  = 2'b01;
  localparam [1:0] ST_TAKE  = 2'b10;
  localparam [2:0] LAT_MIN  = `MIC_LAT_MIN_ICYC;

  wire [2:0]  pin_sync;
  wire [2:0]  pin_rise;
  wire [10:0] per_rise;
  reg  [7:0]  irq_control_reg;
  reg  [7:0]  peripheral_flag_reg_a;
  reg  [7:0]  peripheral_flag_reg_b;
  reg  [7:0]  peripheral_mask_reg_a;
  reg  [7:0]  peripheral_mask_reg_b;
  reg  [1:0]  evt_status_reg;
  reg  [1:0]  evt_mask_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  lat_cnt_reg;
  reg  [2:0]  lat_cnt_next;
  reg         in_service_reg;
  reg  [7:0]  control_next;
  reg  [7:0]  flag_a_next;
  reg  [7:0]  flag_b_next;
  reg  [7:0]  rdata_next;
  wire        periph_pending;
  wire        core_pending;
  wire        pending;
  wire        take_now;

  // Pin inputs pass two flops first
  mic_sync #(.W(3)) u_sync (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async ({i_timer_zero_ovf, i_port_change, i_external_irq_pin}),
    .o_sync  (pin_sync)
  );

  // Event pulses on rising edges
  mic_edge #(.W(3)) u_pin_edge (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_level (pin_sync),
    .o_rise  (pin_rise)
  );

  mic_edge #(.W(11)) u_per_edge (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_level (i_periph_event),
    .o_rise  (per_rise)
  );

  // ****************************************************
  // Pending logic
  // ****************************************************
  assign periph_pending = |(peripheral_flag_reg_a & peripheral_mask_reg_a)
                        | |(peripheral_flag_reg_b & peripheral_mask_reg_b
                            & `MIC_PFLAG_B_USED);
  assign core_pending =
      (irq_control_reg[`MIC_CTL_T0_FLAG]  & irq_control_reg[`MIC_CTL_T0_MASK])
    | (irq_control_reg[`MIC_CTL_EXT_FLAG] & irq_control_reg[`MIC_CTL_EXT_MASK])
    | (irq_control_reg[`MIC_CTL_PCH_FLAG]
       & irq_control_reg[`MIC_CTL_PCH_MASK]);
  assign pending  = core_pending
                  | (periph_pending
                     & irq_control_reg[`MIC_CTL_PER_EN]);
  assign take_now = (state_reg == ST_TAKE) & i_icyc_end
                  & irq_control_reg[`MIC_CTL_GLB_EN] & pending;

  // ****************************************************
  // Control register next value
  // ****************************************************
  always @*
  begin
    control_next = irq_control_reg;
    if (i_wr && i_addr == `MIC_OFF_CONTROL)
      control_next = i_wdata;
    if (i_return_from_irq)
      control_next[`MIC_CTL_GLB_EN] = 1'b1;
    if (take_now)
      control_next[`MIC_CTL_GLB_EN] = 1'b0;
    // Set wins over a software clear
    if (pin_rise[0])
      control_next[`MIC_CTL_EXT_FLAG] = 1'b1;
    if (pin_rise[1])
      control_next[`MIC_CTL_PCH_FLAG] = 1'b1;
    if (pin_rise[2])
      control_next[`MIC_CTL_T0_FLAG] = 1'b1;
  end

  // Peripheral flag next values, event beats clear
  always @*
  begin
    flag_a_next = peripheral_flag_reg_a;
    flag_b_next = peripheral_flag_reg_b;
    if (i_wr && i_addr == `MIC_OFF_PFLAG_A)
      flag_a_next = i_wdata;
    if (i_wr && i_addr == `MIC_OFF_PFLAG_B)
      flag_b_next = i_wdata & `MIC_PFLAG_B_USED;
    flag_a_next = flag_a_next | per_rise[7:0];
    flag_b_next = flag_b_next | {5'h00, per_rise[10:8]};
  end

  // ****************************************************
  // Acceptance sequencer, counts instruction cycles
  // ****************************************************
  always @*
  begin
    state_next   = state_reg;
    lat_cnt_next = lat_cnt_reg;
    case (state_reg)
      ST_RUN:
        if (pending && irq_control_reg[`MIC_CTL_GLB_EN] && !in_service_reg)
        begin
          state_next   = ST_WAIT;
          lat_cnt_next = 3'h1;
        end
      ST_WAIT:
        if (!(pending && irq_control_reg[`MIC_CTL_GLB_EN]))
          state_next = ST_RUN;
        else if (i_icyc_end)
        begin
          lat_cnt_next = lat_cnt_reg + 3'h1;
          if (lat_cnt_reg == LAT_MIN - 3'h1)
            state_next = ST_TAKE;
        end
      ST_TAKE:
        if (take_now)
          state_next = ST_RUN;
        else if (!(pending && irq_control_reg[`MIC_CTL_GLB_EN]))
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  // Read mux, status read clears sticky events
  always @*
  begin
    case (i_addr)
      `MIC_OFF_CONTROL:    rdata_next = irq_control_reg;
      `MIC_OFF_PFLAG_A:    rdata_next = peripheral_flag_reg_a;
      `MIC_OFF_PFLAG_B:    rdata_next = peripheral_flag_reg_b;
      `MIC_OFF_PMASK_A:    rdata_next = peripheral_mask_reg_a;
      `MIC_OFF_PMASK_B:    rdata_next = peripheral_mask_reg_b;
      `MIC_OFF_EVT_STATUS: rdata_next = {6'h00, evt_status_reg};
      `MIC_OFF_EVT_MASK:   rdata_next = {6'h00, evt_mask_reg};
      `MIC_OFF_CORE_STATE: rdata_next = {4'h0, pending, in_service_reg,
                                         state_reg};
      default:             rdata_next = 8'h00;
    endcase
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Control and request flag registers
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      irq_control_reg       <= `MIC_CONTROL_RST;
      peripheral_flag_reg_a <= `MIC_PFLAG_RST;
      peripheral_flag_reg_b <= `MIC_PFLAG_RST;
    end
    else
    begin
      irq_control_reg       <= control_next;
      peripheral_flag_reg_a <= flag_a_next;
      peripheral_flag_reg_b <= flag_b_next;
    end
  end

  // Mask registers, written by software only
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      peripheral_mask_reg_a <= `MIC_PMASK_RST;
      peripheral_mask_reg_b <= `MIC_PMASK_RST;
      evt_mask_reg          <= 2'h0;
    end
    else
    begin
      if (i_wr && i_addr == `MIC_OFF_PMASK_A)
        peripheral_mask_reg_a <= i_wdata;
      if (i_wr && i_addr == `MIC_OFF_PMASK_B)
        peripheral_mask_reg_b <= i_wdata & `MIC_PFLAG_B_USED;
      if (i_wr && i_addr == `MIC_OFF_EVT_MASK)
        evt_mask_reg <= i_wdata[1:0];
    end
  end

  // Sticky events: bit0 taken, bit1 returned; set beats read clear
  always @(posedge i_clock)
  begin
    if (!i_rstn)
      evt_status_reg <= 2'h0;
    else
      evt_status_reg <= ((i_rd && i_addr == `MIC_OFF_EVT_STATUS)
                         ? 2'h0 : evt_status_reg)
                        | {i_return_from_irq, take_now};
  end

  // Sequencer state and service marker
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state_reg      <= ST_RUN;
      lat_cnt_reg    <= 3'h0;
      in_service_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      lat_cnt_reg <= lat_cnt_next;
      // Acceptance beats a return in the same cycle
      if (take_now)
        in_service_reg <= 1'b1;
      else if (i_return_from_irq)
        in_service_reg <= 1'b0;
    end
  end

  // Read data stands one cycle, zero otherwise
  always @(posedge i_clock)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else
      o_rdata <= i_rd ? rdata_next : 8'h00;
  end

  // Core-side redirect: vector, push and return address
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_vector_take <= 1'b0;
      o_vector_pc   <= `MIC_VECTOR;
      o_stack_push  <= 1'b0;
      o_stack_data  <= {`MIC_PC_W{1'b0}};
    end
    else
    begin
      o_vector_take <= take_now;
      o_vector_pc   <= `MIC_VECTOR;
      o_stack_push  <= take_now;
      if (take_now)
        o_stack_data <= i_return_pc;
    end
  end

  // Level interrupt from unmasked sticky events
  always @(posedge i_clock)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(evt_status_reg & evt_mask_reg);
  end

endmodule
`default_nettype wire

//--- src/mic_sync.v
// Two-flop synchroniser bank for pin-side inputs
`timescale 1ns/1ps
`default_nettype none

module mic_sync #(
  parameter W = 3
) (
  input  wire         i_clock,
  input  wire         i_rstn,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta_reg;

  // ****************************************************
  // Two flip-flops, first read only by second
  // ****************************************************
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      meta_reg <= {W{1'b0}};
      o_sync   <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

//--- tb/mic_core_model.sv
// Core-side partner: instruction cycle marker and return pulse
`timescale 1ns/1ps
`default_nettype none
module mic_core_model #(
  parameter RET_PC = 13'h0123
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_do_ret,
  output var  logic        o_icyc_end,
  output var  logic        o_ret,
  output wire logic [12:0] o_ret_pc
);
  logic [1:0] phase_reg;
  logic       pend_reg;

  // Return address the core would push
  assign o_ret_pc = RET_PC;

  // Marker every fourth clock; a requested return lands on a marker
  always @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      phase_reg  <= 2'h0;
      pend_reg   <= 1'b0;
      o_icyc_end <= 1'b0;
      o_ret      <= 1'b0;
    end
    else
    begin
      phase_reg  <= phase_reg + 2'h1;
      o_icyc_end <= (phase_reg == 2'h2);
      o_ret      <= pend_reg && (phase_reg == 2'h2);
      pend_reg   <= i_do_ret || (pend_reg && (phase_reg != 2'h2));
    end
  end
endmodule
`default_nettype wire

//--- tb/mic_irq_chk.sv
// Port assertions of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_chk (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [12:0] i_return_pc,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_vector_take,
  input wire logic [12:0] o_vector_pc,
  input wire logic        o_stack_push,
  input wire logic [12:0] o_stack_data,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_take; o_vector_take; endsequence
  sequence s_quiet; !o_vector_take [*8]; endsequence

  vec_addr_a:
    assert property (o_vector_pc == 13'h0004) else $error("bad vector");
  take_push_a:
    assert property (o_vector_take == o_stack_push) else $error("push");
  take_once_a:
    assert property (s_take |=> s_quiet) else $error("double take");
  stack_data_a:
    assert property (s_take |-> o_stack_data == $past(i_return_pc))
      else $error("bad return address");
  reset_quiet_a:
    assert property (disable iff (1'b0)
      !i_rstn |=> !o_vector_take && !o_stack_push && !o_irq)
      else $error("active in reset");
  rdata_idle_a:
    assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata");
  unmapped_rd_a:
    assert property (i_rd && i_addr > 4'h7 |=> o_rdata == 8'h00)
      else $error("unmapped read");
  irq_fall_a:
    assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_wr)
      || $past(i_rd, 2) || $past(i_wr, 2)) else $error("irq dropped");
endmodule
bind mic_irq_ctrl mic_irq_chk chk_u (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_return_pc(i_return_pc),
  .o_rdata(o_rdata), .o_vector_take(o_vector_take),
  .o_vector_pc(o_vector_pc), .o_stack_push(o_stack_push),
  .o_stack_data(o_stack_data), .o_irq(o_irq));
`default_nettype wire

//--- tb/tb_top.sv
// Register-level testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clock = 1'b0;
  logic        i_rstn = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic        do_ret = 1'b0;
  logic        icyc, ret, take, push, irq;
  logic [12:0] rpc, vpc, sdata;
  logic [7:0]  o_rdata;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n;
  int          i;

  // ****************************************************
  // Design and partner
  // ****************************************************
  mic_core_model core_u (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_do_ret(do_ret), .o_icyc_end(icyc), .o_ret(ret), .o_ret_pc(rpc));
  mic_irq_ctrl dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_external_irq_pin(ev[0]), .i_port_change(ev[1]),
    .i_timer_zero_ovf(ev[2]), .i_periph_event(ev[13:3]),
    .i_icyc_end(icyc), .i_return_from_irq(ret), .i_return_pc(rpc),
    .o_vector_take(take), .o_vector_pc(vpc), .o_stack_push(push),
    .o_stack_data(sdata), .o_irq(irq));

  always #25 i_clock = ~i_clock;

  // ****************************************************
  // Tasks
  // ****************************************************
  task give_verdict;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [12:0] s, input [12:0] e);
    begin
      total_checks++;
      if (s !== e)
      begin
        n_fail++;
        $display("Error at %0t: saw %h, expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk({5'h00, o_rdata}, {5'h00, e});
    end
  endtask
  task evt(input [13:0] m);
    begin
      @(posedge i_clock);
      ev <= m;
      repeat (2) @(posedge i_clock);
      ev <= 14'h0000;
      repeat (5) @(posedge i_clock);
    end
  endtask
  task wait_take;
    begin
      n = 0;
      while (take !== 1'b1 && n < 80)
      begin
        @(posedge i_clock);
        #1;
        n++;
      end
      if (n >= 80)
      begin
        n_fail++;
        give_verdict;
      end
    end
  endtask
  task no_take;
    begin
      repeat (60)
      begin
        @(posedge i_clock);
        #1;
        chk({12'h000, take}, 13'h0000);
      end
    end
  endtask
  task give_ret;
    begin
      @(posedge i_clock);
      do_ret <= 1'b1;
      @(posedge i_clock);
      do_ret <= 1'b0;
      repeat (8) @(posedge i_clock);
    end
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (i = 0; i < 8; i++)
      rd(i[3:0], 8'h00);
    rd(4'hf, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    // Every source flags with all masks and enables off
    evt(14'h3fff);
    rd(4'h0, 8'h07);
    rd(4'h1, 8'hff);
    rd(4'h2, 8'h07);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h3f);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    // Peripheral request gated by both enables
    wr(4'h6, 8'h03);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h80);
    evt(14'h0008);
    no_take;
    wr(4'h0, 8'h40);
    no_take;
    wr(4'h0, 8'hc0);
    wait_take;
    chk(sdata, 13'h0123);
    rd(4'h0, 8'h40);
    rd(4'h1, 8'h01);
    chk({12'h000, irq}, 13'h0001);
    rd(4'h5, 8'h01);
    repeat (2) @(posedge i_clock);
    #1;
    chk({12'h000, irq}, 13'h0000);
    // Return with the flag still set fires again
    give_ret;
    wait_take;
    wr(4'h1, 8'h00);
    give_ret;
    rd(4'h0, 8'hc0);
    no_take;
    // Pin and port change latency
    wr(4'h0, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(4'h0, i ? 8'h88 : 8'h90);
      @(posedge i_clock);
      ev <= i ? 14'h0002 : 14'h0001;
      wait_take;
      ev <= 14'h0000;
      chk({12'h000, n >= 12 && n <= 17}, 13'h0001);
      rd(4'h0, i ? 8'h09 : 8'h12);
      wr(4'h0, i ? 8'h08 : 8'h10);
      give_ret;
      rd(4'h5, 8'h03);
      wr(4'h0, 8'h00);
    end
    // Mid-run reset clears the global enable again
    wr(4'h0, 8'h80);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(4'h0, 8'h00);
    give_verdict;
  end
endmodule
`default_nettype wire
